// ===== rtl/sample_filter.sv
`timescale 1ns/1ps
// Configurable single-channel sample filter with an AXI4-Lite register slave.
module sample_filter #(
  parameter int FIFO_DEPTH = 32,
  parameter int TICK_CYCLES = sample_filter_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Sample source: converter (12 bit) or timer (15 bit).
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire logic [15:0] i_sample_data,
  input wire logic i_sample_from_timer,
  // Filtered value to downstream consumers.
  output logic [15:0] o_value,
  output logic o_value_strobe,
  // AXI4-Lite slave.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  localparam int SW = sample_filter_pkg::SAMPLE_W;
  localparam int AW = sample_filter_pkg::ACC_W;
  localparam int NC = sample_filter_pkg::NUM_COEF;

  typedef struct packed {
    sample_filter_pkg::filter_cfg_t cfg;
    logic [31:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic [15:0] latest;
    logic [AW-1:0] sum;
    logic [15:0] rep_cnt;
    logic [2:0][15:0] in_hist;
    logic [2:0][15:0] out_hist;
    logic [15:0] value;
    logic strobe;
    logic [7:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } state_t;

  state_t st_r, st_nxt;
  logic fifo_valid, fifo_take;
  sample_filter_pkg::sample_t fifo_in, fifo_out;
  logic signed [AW-1:0] lp_acc;
  logic signed [AW-1:0] lp_shift;
  logic signed [AW-1:0] mv_diff;

  // The FIFO decouples the bursty source from the filter, which drains it one sample per cycle.
  assign fifo_in.data = i_sample_data;
  assign fifo_in.from_timer = i_sample_from_timer;
  sample_fifo #(
    .WIDTH($bits(sample_filter_pkg::sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(i_sample_valid),
    .o_in_ready(o_sample_ready),
    .i_in_data(fifo_in),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_take),
    .o_out_data(fifo_out)
  );

  // Samples are drained one per cycle; latest keeps the newest one only.
  assign fifo_take = fifo_valid;

  // Low-pass weighted sum; operands are widened first so no product is cut to 16 bits.
  always_comb begin
    lp_acc = '0;
    lp_acc = lp_acc + AW'($signed(st_r.cfg.coef[0])) * AW'($signed(st_r.latest));
    for (int k = 0; k < 3; k++) begin
      lp_acc = lp_acc + AW'($signed(st_r.cfg.coef[k+1])) * AW'($signed(st_r.in_hist[k]));
      lp_acc = lp_acc + AW'($signed(st_r.cfg.coef[k+4])) * AW'($signed(st_r.out_hist[k]));
    end
    lp_shift = lp_acc >>> st_r.cfg.power;
    mv_diff = AW'($signed({1'b0, st_r.latest})) - AW'($signed({1'b0, st_r.value}));
  end

  // Next-state logic for the filter datapath and the bus slave.
  always_comb begin
    logic tick;
    logic period_hit;
    logic [15:0] wsel;
    tick = 1'b0;
    period_hit = 1'b0;
    wsel = '0;
    st_nxt = st_r;
    st_nxt.strobe = 1'b0;

    // Millisecond tick divider.
    if (st_r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      st_nxt.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
    end

    // Capture the latest sample; the timer carries 15 bits, converter 12.
    if (fifo_valid) begin
      st_nxt.latest = fifo_out.from_timer ? {1'b0, fifo_out.data[14:0]}
                                          : {4'h0, fifo_out.data[11:0]};
    end

    unique case (st_r.cfg.ftype)
      sample_filter_pkg::FT_PASS: begin
        st_nxt.value = st_nxt.latest;
        st_nxt.strobe = fifo_valid;
      end
      sample_filter_pkg::FT_MOVING: begin
        if (tick) begin
          if (st_r.cfg.divisor == 16'h0) begin
            st_nxt.value = st_r.latest;
          end else begin
            st_nxt.value = 16'(AW'($signed({1'b0, st_r.value}))
                           + mv_diff / AW'($signed({1'b0, st_r.cfg.divisor})));
          end
          st_nxt.strobe = 1'b1;
        end
      end
      sample_filter_pkg::FT_REPEAT: begin
        if (tick) begin
          if (st_r.cfg.divisor == 16'h0) begin
            st_nxt.value = st_r.latest;
            st_nxt.strobe = 1'b1;
          end else if (st_r.rep_cnt + 16'h1 >= st_r.cfg.divisor) begin
            st_nxt.value = 16'((st_r.sum + AW'(st_r.latest)) / AW'(st_r.cfg.divisor));
            st_nxt.sum = '0;
            st_nxt.rep_cnt = '0;
            st_nxt.strobe = 1'b1;
          end else begin
            st_nxt.sum = st_r.sum + AW'(st_r.latest);
            st_nxt.rep_cnt = st_r.rep_cnt + 16'h1;
          end
        end
      end
      sample_filter_pkg::FT_LOWPASS: begin
        if (tick) begin
          if (st_r.ms_cnt + 16'h1 >= st_r.cfg.period_ms) begin
            period_hit = 1'b1;
            st_nxt.ms_cnt = '0;
          end else begin
            st_nxt.ms_cnt = st_r.ms_cnt + 16'h1;
          end
        end
        if (period_hit) begin
          st_nxt.value = lp_shift[15:0];
          st_nxt.in_hist = {st_r.in_hist[1:0], st_r.latest};
          st_nxt.out_hist = {st_r.out_hist[1:0], lp_shift[15:0]};
          st_nxt.strobe = 1'b1;
        end
      end
    endcase

    // Write channel: address and data are taken in either order.
    if (i_awvalid && !st_r.aw_held && !st_r.bvalid) begin
      st_nxt.awaddr = i_awaddr;
      st_nxt.aw_held = 1'b1;
    end
    if (i_wvalid && !st_r.w_held && !st_r.bvalid) begin
      st_nxt.wdata = i_wdata;
      st_nxt.wstrb = i_wstrb;
      st_nxt.w_held = 1'b1;
    end
    if (st_r.aw_held && st_r.w_held) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = sample_filter_pkg::RESP_OKAY;
      wsel = {st_r.wstrb[1] ? st_r.wdata[15:8] : 8'h0, st_r.wstrb[0] ? st_r.wdata[7:0] : 8'h0};
      unique case (st_r.awaddr)
        sample_filter_pkg::ADDR_CTRL: begin
          if (st_r.wstrb[0]) begin
            st_nxt.cfg.ftype = sample_filter_pkg::filter_type_t'(st_r.wdata[1:0]);
            // Writing the type clears sum, rep_cnt, ms_cnt and the low-pass history; value and latest are kept.
            st_nxt.sum = '0;
            st_nxt.rep_cnt = '0;
            st_nxt.ms_cnt = '0;
            st_nxt.in_hist = '0;
            st_nxt.out_hist = '0;
          end
        end
        sample_filter_pkg::ADDR_DIVISOR: begin
          st_nxt.cfg.divisor = (wsel & {st_r.wstrb[1] ? 8'hFF : 8'h0, st_r.wstrb[0] ? 8'hFF : 8'h0})
                               | (st_r.cfg.divisor & {st_r.wstrb[1] ? 8'h0 : 8'hFF,
                                                      st_r.wstrb[0] ? 8'h0 : 8'hFF});
        end
        sample_filter_pkg::ADDR_POWER: begin
          if (st_r.wstrb[0]) begin
            st_nxt.cfg.power = st_r.wdata[4:0];
          end
        end
        sample_filter_pkg::ADDR_PERIOD: begin
          st_nxt.cfg.period_ms = (wsel & {st_r.wstrb[1] ? 8'hFF : 8'h0, st_r.wstrb[0] ? 8'hFF : 8'h0})
                                 | (st_r.cfg.period_ms & {st_r.wstrb[1] ? 8'h0 : 8'hFF,
                                                          st_r.wstrb[0] ? 8'h0 : 8'hFF});
        end
        default: begin
          if (st_r.awaddr >= sample_filter_pkg::ADDR_COEF0
              && st_r.awaddr < sample_filter_pkg::ADDR_COEF0 + 8'(4 * NC)
              && st_r.awaddr[1:0] == 2'h0) begin
            st_nxt.cfg.coef[3'((st_r.awaddr - sample_filter_pkg::ADDR_COEF0) >> 2)]
              = (wsel & {st_r.wstrb[1] ? 8'hFF : 8'h0, st_r.wstrb[0] ? 8'hFF : 8'h0})
                | (st_r.cfg.coef[3'((st_r.awaddr - sample_filter_pkg::ADDR_COEF0) >> 2)]
                   & {st_r.wstrb[1] ? 8'h0 : 8'hFF, st_r.wstrb[0] ? 8'h0 : 8'hFF});
          end else if (st_r.awaddr != sample_filter_pkg::ADDR_VALUE
                       && st_r.awaddr != sample_filter_pkg::ADDR_COUNT) begin
            st_nxt.bresp = sample_filter_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Read channel: one-cycle decode, answer held until rready.
    if (i_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = sample_filter_pkg::RESP_OKAY;
      st_nxt.rdata = '0;
      unique case (i_araddr)
        sample_filter_pkg::ADDR_CTRL: st_nxt.rdata = 32'(st_r.cfg.ftype);
        sample_filter_pkg::ADDR_DIVISOR: st_nxt.rdata = 32'(st_r.cfg.divisor);
        sample_filter_pkg::ADDR_POWER: st_nxt.rdata = 32'(st_r.cfg.power);
        sample_filter_pkg::ADDR_PERIOD: st_nxt.rdata = 32'(st_r.cfg.period_ms);
        sample_filter_pkg::ADDR_VALUE: st_nxt.rdata = 32'(st_r.value);
        sample_filter_pkg::ADDR_COUNT: st_nxt.rdata = 32'(st_r.rep_cnt);
        default: begin
          if (i_araddr >= sample_filter_pkg::ADDR_COEF0
              && i_araddr < sample_filter_pkg::ADDR_COEF0 + 8'(4 * NC)
              && i_araddr[1:0] == 2'h0) begin
            st_nxt.rdata = 32'(st_r.cfg.coef[3'((i_araddr - sample_filter_pkg::ADDR_COEF0) >> 2)]);
          end else begin
            st_nxt.rresp = sample_filter_pkg::RESP_SLVERR;
          end
        end
      endcase
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Ready flags are registered copies of the next holding state, so ports come from flops.
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
  end

  // All state clears on reset, including history and output.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign o_value = st_r.value;
  assign o_value_strobe = st_r.strobe;
  assign o_awready = st_r.awready;
  assign o_wready = st_r.wready;
  assign o_bvalid = st_r.bvalid;
  assign o_bresp = st_r.bresp;
  assign o_arready = st_r.arready;
  assign o_rvalid = st_r.rvalid;
  assign o_rdata = st_r.rdata;
  assign o_rresp = st_r.rresp;
endmodule : sample_filter

// ===== rtl/sample_filter_pkg.sv
package sample_filter_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 48;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIVISOR = 8'h04;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_VALUE = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_COEF0 = 8'h20;
  localparam int NUM_COEF = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FT_PASS = 2'h0,
    FT_MOVING = 2'h1,
    FT_REPEAT = 2'h2,
    FT_LOWPASS = 2'h3
  } filter_type_t;

  typedef struct packed {
    logic [15:0] data;
    logic from_timer;
  } sample_t;

  typedef struct packed {
    filter_type_t ftype;
    logic [15:0] divisor;
    logic [4:0] power;
    logic [15:0] period_ms;
    logic [NUM_COEF-1:0][15:0] coef;
  } filter_cfg_t;

endpackage : sample_filter_pkg

// ===== rtl/sample_fifo.sv
`timescale 1ns/1ps
// Synchronous FIFO; input ready falls when full so the source stalls.
module sample_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_st_t;
  fifo_st_t st_r, st_nxt;
  logic do_wr, do_rd, full, empty;

  // Full when pointers differ only in the wrap bit.
  always_comb begin
    empty = (st_r.wp == st_r.rp);
    full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
    do_wr = i_in_valid && !full;
    do_rd = !empty && i_out_ready;
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (do_rd) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage has no reset; only pointers need a defined value.
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[st_r.wp[AW-1:0]] <= i_in_data;
    end
  end

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[st_r.rp[AW-1:0]];
endmodule : sample_fifo

// ===== verification/sample_filter_checker.sv
`timescale 1ns/1ps
// Bus and output timing checks; the filter arithmetic is judged by the bench.
module sample_filter_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] o_value,
  input wire logic o_value_strobe,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready
);
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_take;
    i_arvalid && o_arready;
  endsequence
  property p_value_hold;
    !$stable(o_value) |-> o_value_strobe;
  endproperty
  a_value_hold: assert property (p_value_hold) else $error("value moved without strobe");
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_ar_block;
    o_rvalid |-> !o_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready while rvalid");
  property p_aw_block;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write ready while bvalid");
  property p_wr_answer;
    s_wr_take |-> ##[1:2] o_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_rd_take |=> o_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
  property p_unmapped;
    s_rd_take and i_araddr == 8'hFC |=> o_rresp == 2'h2 && o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule : sample_filter_checker
bind sample_filter sample_filter_checker i_sample_filter_checker (.i_clk(i_clk), .i_rst(i_rst),
  .o_value(o_value), .o_value_strobe(o_value_strobe), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));

// ===== verification/sample_source.sv
`timescale 1ns/1ps
// Converter stand-in: offers a sample after every eight idle cycles and holds it until taken.
module sample_source (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic [15:0] i_data,
  input wire logic i_from_timer,
  input wire logic i_ready,
  output logic o_valid,
  output logic [15:0] o_data,
  output logic o_from_timer
);
  logic [2:0] gap_r;
  // Outside an offer the data lines flip, so a stale word is never mistaken for a sample.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'h0;
      gap_r <= 3'h0;
      o_data <= 16'h0;
      o_from_timer <= 1'h0;
    end else if (o_valid) begin
      if (i_ready) begin
        o_valid <= 1'h0;
        o_data <= ~o_data;
      end
    end else begin
      gap_r <= gap_r + 3'h1;
      o_data <= ~o_data;
      if (gap_r == 3'h7 && i_enable) begin
        o_valid <= 1'h1;
        o_data <= i_data;
        o_from_timer <= i_from_timer;
      end
    end
  end
endmodule : sample_source

// ===== verification/tb.sv
`timescale 1ns/1ps
// Register-level tests of the filter through its bus and a paced sample source.
module tb;
  localparam int TICK = 20;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  logic src_en = 1'h0;
  logic src_timer = 1'h0;
  logic [15:0] src_data = 16'h0;
  logic s_valid, s_ready, s_timer, awready, wready, bvalid, arready, rvalid, strobe;
  logic [15:0] s_data, value, v;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0;
  int compares = 0;
  int c;
  always #5 i_clk = ~i_clk;
  sample_source i_sample_source (.i_clk(i_clk), .i_rst(i_rst), .i_enable(src_en),
    .i_data(src_data), .i_from_timer(src_timer), .i_ready(s_ready), .o_valid(s_valid),
    .o_data(s_data), .o_from_timer(s_timer));
  // Responses are always accepted at once; the bench never exercises back-pressure there.
  sample_filter #(.FIFO_DEPTH(32), .TICK_CYCLES(TICK)) i_sample_filter (.i_clk(i_clk),
    .i_rst(i_rst), .i_sample_valid(s_valid), .o_sample_ready(s_ready), .i_sample_data(s_data),
    .i_sample_from_timer(s_timer), .o_value(value), .o_value_strobe(strobe),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(1'h1), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'h1));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic hang();
    n_errors++;
    $display("ERROR %0t: wait ran out", $time);
    summarize();
  endtask : hang
  // Handshakes are judged at the falling edge, where ready is settled, then released after the rise.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, done;
    done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge i_clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      done = bvalid;
      if (done) chk(bresp, er);
      @(posedge i_clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
    end
    if (!done) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, done;
    done = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge i_clk);
      ah = arvalid && arready;
      done = rvalid;
      if (done) chk(rdata, ed);
      if (done) chk(rresp, er);
      @(posedge i_clk);
      if (ah) arvalid <= 1'h0;
    end
    if (!done) hang();
  endtask : rd
  // Waits for the next strobe, returning its value and the cycles counted from the start of this call.
  task automatic ws();
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (strobe !== 1'h1 && c < 2000);
    if (c >= 2000) hang();
    v = value;
    @(posedge i_clk);
  endtask : ws
  task automatic wnz();
    src_en <= 1'h1;
    for (int n = 0; n < 30 && v === 16'h0; n++) ws();
  endtask : wnz
  task automatic restart(input logic [1:0] ft, input logic [15:0] dv);
    src_en <= 1'h0;
    i_rst <= 1'h1;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    rd(sample_filter_pkg::ADDR_VALUE, 32'h0, 2'h0);
    rd(sample_filter_pkg::ADDR_COUNT, 32'h0, 2'h0);
    wr(sample_filter_pkg::ADDR_DIVISOR, {16'h0, dv}, 2'h0);
    wr(sample_filter_pkg::ADDR_CTRL, {30'h0, ft}, 2'h0);
    src_data <= 16'h0064;
    v = 16'h0;
  endtask : restart
  initial begin
    restart(2'h0, 16'h2345);
    rd(sample_filter_pkg::ADDR_DIVISOR, 32'h2345, 2'h0);
    wr(8'hFC, 32'h0, 2'h2);
    rd(8'hFC, 32'h0, 2'h2);
    src_data <= 16'hFABC;
    wnz();
    chk(v, 16'h0ABC);
    src_timer <= 1'h1;
    ws();
    ws();
    chk(v, 16'h7ABC);
    $display("pass-through test done");
    restart(2'h1, 16'h0004);
    wnz();
    chk(v, 16'h0019);
    ws();
    chk(v, 16'h002B);
    chk(c, TICK);
    restart(2'h1, 16'h0000);
    wnz();
    chk(v, 16'h0064);
    $display("moving average test done");
    restart(2'h2, 16'h0004);
    wnz();
    ws();
    chk(v, 16'h0064);
    chk(c, 4 * TICK);
    $display("repeating average test done");
    restart(2'h0, 16'h0000);
    wr(sample_filter_pkg::ADDR_COEF0, 32'h0080, 2'h0);
    wr(sample_filter_pkg::ADDR_COEF0 + 8'h10, 32'h0080, 2'h0);
    wr(sample_filter_pkg::ADDR_POWER, 32'h0008, 2'h0);
    wr(sample_filter_pkg::ADDR_PERIOD, 32'h0003, 2'h0);
    wr(sample_filter_pkg::ADDR_CTRL, 32'h0003, 2'h0);
    wnz();
    chk(v, 16'h0032);
    ws();
    chk(v, 16'h004B);
    chk(c, 3 * TICK);
    $display("low-pass test done");
    summarize();
  end
endmodule : tb
